/* File: hdl/boot_links.v */
// Boot loader serial link front end: boot decision and three slave links
`timescale 1ns/1ps
`include "boot_links_defines.vh"

module boot_links (
    input wire clk,
    input wire rst_n,
    input wire flash_words_all_ones,
    input wire warm_entry,
    input wire [1:0] warm_link,
    input wire [15:0] warm_bit_period,
    input wire two_wire_master_enabled,
    output wire boot_loader_active,
    output wire run_application,
    output wire [1:0] active_link,
    output wire baud_locked,
    output wire rx_overrun,
    input wire async_rx_pin,
    output wire async_tx_pin,
    input wire sync_frame_select_pin,
    input wire sync_serial_clock_pin,
    input wire sync_rx_pin,
    output wire sync_tx_pin,
    input wire two_wire_clock_pin,
    input wire two_wire_data_in,
    output wire two_wire_data_out,
    output wire two_wire_data_oe,
    output wire rx_valid,
    input wire rx_ready,
    output wire [7:0] rx_data,
    input wire tx_valid,
    output wire tx_ready,
    input wire [7:0] tx_data
);
    // Async receiver states
    localparam A_IDLE = 3'h0;
    localparam A_MEAS = 3'h1;
    localparam A_WAIT = 3'h2;
    localparam A_START = 3'h3;
    localparam A_DATA = 3'h4;
    localparam A_STOP = 3'h5;
    // Two-wire slave states
    localparam W_IDLE = 3'h0;
    localparam W_ADDR = 3'h1;
    localparam W_AACK = 3'h2;
    localparam W_WR = 3'h3;
    localparam W_DACK = 3'h4;
    localparam W_RD = 3'h5;
    localparam W_RACK = 3'h6;

    reg decided_reg, boot_reg, app_reg, warm_reg;
    reg [1:0] link_reg;
    reg overrun_reg;
    reg [5:0] prev_reg;
    reg [2:0] a_state_reg;
    reg [15:0] a_cnt_reg, a_per_reg;
    reg [2:0] a_bits_reg;
    reg [7:0] a_sh_reg;
    reg a_lock_reg;
    reg [9:0] t_sh_reg;
    reg [15:0] t_cnt_reg;
    reg [3:0] t_bits_reg;
    reg [7:0] q_rx_reg, q_tx_reg;
    reg [3:0] q_cnt_reg;
    reg q_bit_reg;
    reg [2:0] w_state_reg;
    reg [3:0] w_cnt_reg;
    reg [7:0] w_sh_reg;
    reg w_rw_reg, w_oe_reg;
    wire [5:0] pins;
    wire rx_s, fss_s, sck_s, srx_s, scl_s, sda_s;
    wire rx_fall, fss_fall, sck_rise, sck_fall, scl_rise, scl_fall;
    wire en_async, en_sync, en_wire, ss_en, start_c, stop_c;
    wire a_push, q_push, w_push, a_lock_ev, w_hit, q_take, w_take;
    wire t_take, in_ready, t_idle;
    wire [7:0] tx_byte;
    reg [7:0] in_data;

    // --------------------------------------------
    // Pin synchronisers and edge detection
    // --------------------------------------------
    sync2 #(.W(6)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({async_rx_pin, sync_frame_select_pin, sync_serial_clock_pin,
            sync_rx_pin, two_wire_clock_pin, two_wire_data_in}),
        .q(pins)
    );
    assign {rx_s, fss_s, sck_s, srx_s, scl_s, sda_s} = pins;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_reg <= 6'h3f;
        else
            prev_reg <= pins;
    end

    assign rx_fall = prev_reg[5] && !rx_s;
    assign fss_fall = prev_reg[4] && !fss_s;
    assign sck_rise = !prev_reg[3] && sck_s;
    assign sck_fall = prev_reg[3] && !sck_s;
    assign scl_rise = !prev_reg[1] && scl_s;
    assign scl_fall = prev_reg[1] && !scl_s;

    // --------------------------------------------
    // Boot decision and link ownership
    // --------------------------------------------
    // Strap caught after reset release, never inside the reset branch
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            decided_reg <= 1'b0;
            boot_reg <= 1'b0;
            app_reg <= 1'b0;
            warm_reg <= 1'b0;
            link_reg <= `LINK_NONE;
        end
        else if (!decided_reg)
        begin
            decided_reg <= 1'b1;
            boot_reg <= flash_words_all_ones;
            app_reg <= !flash_words_all_ones;
        end
        else if (warm_entry && !boot_reg)
        begin
            boot_reg <= 1'b1;
            app_reg <= 1'b0;
            warm_reg <= 1'b1;
            link_reg <= warm_link;
        end
        else if (link_reg == `LINK_NONE)
        begin
            // First link with real activity wins for the session
            if (a_lock_ev)
                link_reg <= `LINK_ASYNC;
            else if (en_sync && fss_fall)
                link_reg <= `LINK_SYNC;
            else if (w_hit)
                link_reg <= `LINK_TWO_WIRE;
        end
    end

    assign en_async = boot_reg && (link_reg == `LINK_NONE || link_reg == `LINK_ASYNC);
    assign en_sync = boot_reg && (link_reg == `LINK_NONE || link_reg == `LINK_SYNC);
    assign en_wire = boot_reg && (link_reg == `LINK_NONE || link_reg == `LINK_TWO_WIRE);

    // --------------------------------------------
    // Async receiver with auto-baud
    // --------------------------------------------
    // Bit period is counted in clocks, so any oscillator rate giving MIN_BIT_CLKS to 32767 clocks per bit works
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_state_reg <= A_IDLE;
            a_cnt_reg <= `PER_ZERO;
            a_per_reg <= `PER_ZERO;
            a_bits_reg <= 3'h0;
            a_sh_reg <= 8'h00;
            a_lock_reg <= 1'b0;
        end
        else if (warm_entry && decided_reg && !boot_reg && warm_link == `LINK_ASYNC)
        begin
            a_per_reg <= warm_bit_period;
            a_lock_reg <= 1'b1;
            a_state_reg <= A_IDLE;
        end
        else
        begin
            case (a_state_reg)
                A_IDLE:
                begin
                    a_cnt_reg <= a_lock_reg ? (a_per_reg >> 1) : `PER_ZERO;
                    if (rx_fall && en_async)
                        a_state_reg <= a_lock_reg ? A_START : A_MEAS;
                end
                A_MEAS:
                begin
                    // Low time of the first start bit sets the bit period
                    a_cnt_reg <= a_cnt_reg + `PER_ONE;
                    if (rx_s)
                    begin
                        a_per_reg <= a_cnt_reg + `PER_ONE;
                        a_state_reg <= (a_cnt_reg + `PER_ONE >= `MIN_BIT_CLKS) ? A_WAIT : A_IDLE;
                        a_cnt_reg <= `PER_ZERO;
                    end
                    else if (a_cnt_reg == `PER_MAX)
                        a_state_reg <= A_IDLE;
                end
                A_WAIT:
                begin
                    // Rest of the sync character never holds high two bits
                    a_cnt_reg <= rx_s ? a_cnt_reg + `PER_ONE : `PER_ZERO;
                    if ({1'b0, a_cnt_reg} >= {a_per_reg, 1'b0})
                    begin
                        a_lock_reg <= en_async;
                        a_state_reg <= A_IDLE;
                    end
                end
                A_START:
                begin
                    a_cnt_reg <= a_cnt_reg - `PER_ONE;
                    if (a_cnt_reg == `PER_ZERO)
                    begin
                        a_cnt_reg <= a_per_reg - `PER_ONE;
                        a_bits_reg <= 3'h0;
                        a_state_reg <= rx_s ? A_IDLE : A_DATA; // Glitch filter
                    end
                end
                A_DATA:
                begin
                    a_cnt_reg <= a_cnt_reg - `PER_ONE;
                    if (a_cnt_reg == `PER_ZERO)
                    begin
                        a_sh_reg <= {rx_s, a_sh_reg[7:1]};
                        a_bits_reg <= a_bits_reg + 3'h1;
                        a_cnt_reg <= a_per_reg - `PER_ONE;
                        if (a_bits_reg == `ASYNC_LAST_BIT)
                            a_state_reg <= A_STOP;
                    end
                end
                A_STOP:
                begin
                    a_cnt_reg <= a_cnt_reg - `PER_ONE;
                    if (a_cnt_reg == `PER_ZERO)
                        a_state_reg <= A_IDLE;
                end
                default:
                    a_state_reg <= A_IDLE;
            endcase
        end
    end

    assign a_lock_ev = (a_state_reg == A_WAIT) && ({1'b0, a_cnt_reg} >= {a_per_reg, 1'b0});
    assign a_push = (a_state_reg == A_STOP) && (a_cnt_reg == `PER_ZERO) && rx_s;

    // --------------------------------------------
    // Async transmitter, 8N1 at the found rate
    // --------------------------------------------
    assign t_idle = (t_bits_reg == `BIT_CNT_ZERO);
    assign t_take = t_idle && a_lock_reg && (link_reg == `LINK_ASYNC);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_sh_reg <= `ASYNC_IDLE_WORD;
            t_cnt_reg <= `PER_ZERO;
            t_bits_reg <= `BIT_CNT_ZERO;
        end
        else if (t_take && tx_valid)
        begin
            t_sh_reg <= {1'b1, tx_data, 1'b0};
            t_cnt_reg <= a_per_reg - `PER_ONE;
            t_bits_reg <= `ASYNC_FRAME_BITS;
        end
        else if (!t_idle)
        begin
            t_cnt_reg <= t_cnt_reg - `PER_ONE;
            if (t_cnt_reg == `PER_ZERO)
            begin
                t_sh_reg <= {1'b1, t_sh_reg[9:1]};
                t_cnt_reg <= a_per_reg - `PER_ONE;
                t_bits_reg <= t_bits_reg - `BIT_CNT_ONE;
            end
        end
    end

    assign async_tx_pin = t_sh_reg[0];

    // --------------------------------------------
    // Synchronous serial slave, phase 1 polarity 1
    // --------------------------------------------
    // Output moves on falling clock, input sampled on rising clock
    assign q_take = en_sync && (fss_fall || (!fss_s && sck_rise && q_cnt_reg == `BYTE_LAST));
    assign q_push = en_sync && !fss_s && sck_rise && (q_cnt_reg == `BYTE_LAST);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_rx_reg <= 8'h00;
            q_tx_reg <= `FILLER_BYTE;
            q_cnt_reg <= `BIT_CNT_ZERO;
            q_bit_reg <= 1'b0;
        end
        else if (fss_s || !en_sync)
            q_cnt_reg <= `BIT_CNT_ZERO;
        else if (fss_fall)
            q_tx_reg <= tx_byte;
        else if (sck_fall)
            q_bit_reg <= q_tx_reg[7];
        else if (sck_rise)
        begin
            q_rx_reg <= {q_rx_reg[6:0], srx_s};
            q_tx_reg <= (q_cnt_reg == `BYTE_LAST) ? tx_byte : {q_tx_reg[6:0], 1'b0};
            q_cnt_reg <= (q_cnt_reg == `BYTE_LAST) ? `BIT_CNT_ZERO : q_cnt_reg + `BIT_CNT_ONE;
        end
    end

    assign sync_tx_pin = q_bit_reg;

    // --------------------------------------------
    // Two-wire slave
    // --------------------------------------------
    // Warm entry relies on the local master unit for start and stop
    assign ss_en = !warm_reg || two_wire_master_enabled;
    assign start_c = en_wire && ss_en && scl_s && prev_reg[1] && prev_reg[0] && !sda_s;
    assign stop_c = en_wire && ss_en && scl_s && prev_reg[1] && !prev_reg[0] && sda_s;
    assign w_hit = (w_state_reg == W_ADDR) && scl_fall && (w_cnt_reg == `BYTE_DONE)
        && (w_sh_reg[7:1] == `TWO_WIRE_ADDR);
    assign w_push = (w_state_reg == W_WR) && scl_fall && (w_cnt_reg == `BYTE_DONE);
    assign w_take = scl_fall && ((w_state_reg == W_AACK && w_rw_reg) || w_state_reg == W_RACK);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_state_reg <= W_IDLE;
            w_cnt_reg <= `BIT_CNT_ZERO;
            w_sh_reg <= 8'h00;
            w_rw_reg <= 1'b0;
            w_oe_reg <= 1'b0;
        end
        else if (stop_c || start_c)
        begin
            w_state_reg <= start_c ? W_ADDR : W_IDLE;
            w_cnt_reg <= `BIT_CNT_ZERO;
            w_oe_reg <= 1'b0;
        end
        else
        begin
            case (w_state_reg)
                W_ADDR, W_WR:
                begin
                    if (scl_rise)
                    begin
                        w_sh_reg <= {w_sh_reg[6:0], sda_s};
                        w_cnt_reg <= w_cnt_reg + `BIT_CNT_ONE;
                    end
                    else if (scl_fall && w_cnt_reg == `BYTE_DONE)
                    begin
                        // Full buffer answers with no acknowledge
                        if (w_state_reg == W_ADDR)
                        begin
                            w_rw_reg <= w_sh_reg[0];
                            w_oe_reg <= w_hit;
                            w_state_reg <= w_hit ? W_AACK : W_IDLE;
                        end
                        else
                        begin
                            w_oe_reg <= in_ready;
                            w_state_reg <= in_ready ? W_DACK : W_IDLE;
                        end
                    end
                end
                W_AACK, W_DACK:
                begin
                    if (scl_fall)
                    begin
                        w_cnt_reg <= `BIT_CNT_ZERO;
                        w_state_reg <= w_rw_reg ? W_RD : W_WR;
                        w_oe_reg <= w_rw_reg && !tx_byte[7];
                        w_sh_reg <= tx_byte;
                    end
                end
                W_RD:
                begin
                    if (scl_rise)
                        w_cnt_reg <= w_cnt_reg + `BIT_CNT_ONE;
                    else if (scl_fall && w_cnt_reg == `BYTE_DONE)
                    begin
                        w_oe_reg <= 1'b0;
                        w_state_reg <= W_RACK;
                    end
                    else if (scl_fall)
                    begin
                        w_sh_reg <= {w_sh_reg[6:0], 1'b0};
                        w_oe_reg <= !w_sh_reg[6];
                    end
                end
                W_RACK:
                begin
                    if (scl_rise && sda_s)
                        w_state_reg <= W_IDLE; // Master ended the read
                    else if (scl_fall)
                    begin
                        w_cnt_reg <= `BIT_CNT_ZERO;
                        w_sh_reg <= tx_byte;
                        w_oe_reg <= !tx_byte[7];
                        w_state_reg <= W_RD;
                    end
                end
                default:
                    w_state_reg <= W_IDLE;
            endcase
        end
    end

    assign two_wire_data_out = 1'b0;
    assign two_wire_data_oe = w_oe_reg;

    // --------------------------------------------
    // Byte streams shared by all links
    // --------------------------------------------
    // Nothing queued means a zero filler goes out on the sync and two-wire links; the async transmitter sends nothing
    assign tx_byte = tx_valid ? tx_data : `FILLER_BYTE;
    assign tx_ready = t_take || q_take || w_take;

    always @*
    begin
        in_data = w_sh_reg;
        if (a_push)
            in_data = a_sh_reg;
        else if (q_push)
            in_data = {q_rx_reg[6:0], srx_s};
    end

    // Async and sync hosts cannot be stalled; a lost byte is flagged
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overrun_reg <= 1'b0;
        else if ((a_push || q_push) && !in_ready)
            overrun_reg <= 1'b1;
    end

    byte_fifo2 u_rx_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(a_push || q_push || w_push),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    assign boot_loader_active = boot_reg;
    assign run_application = app_reg;
    assign active_link = link_reg;
    assign baud_locked = a_lock_reg;
    assign rx_overrun = overrun_reg;
endmodule

/* File: common/boot_links_defines.vh */
// Shared constants for the boot loader serial link front end
`ifndef BOOT_LINKS_DEFINES_VH
`define BOOT_LINKS_DEFINES_VH

// Link selection codes
`define LINK_NONE 2'h0
`define LINK_ASYNC 2'h1
`define LINK_SYNC 2'h2
`define LINK_TWO_WIRE 2'h3

// Asynchronous link timing
`define PER_W 16
`define PER_ONE 16'h0001
`define PER_ZERO 16'h0000
`define PER_MAX 16'hffff
`define MIN_BIT_CLKS 16'h0020
`define ASYNC_LAST_BIT 3'h7
`define ASYNC_FRAME_BITS 4'ha
`define ASYNC_IDLE_WORD 10'h3ff

// Byte framing
`define BIT_CNT_W 4
`define BIT_CNT_ONE 4'h1
`define BIT_CNT_ZERO 4'h0
`define BYTE_LAST 4'h7
`define BYTE_DONE 4'h8
`define FILLER_BYTE 8'h00

// Two-wire slave address
`define TWO_WIRE_ADDR 7'h42

`endif

/* File: hdl/sync2.v */
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps

module sync2 #(
    parameter W = 1
)(
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // --------------------------------------------
    // Idle pins rest high, so reset to ones
    // --------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= {W{1'b1}};
            sync_reg <= {W{1'b1}};
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

/* File: hdl/byte_fifo2.v */
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps

module byte_fifo2 (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [7:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [7:0] out_data
);
    reg [7:0] head_reg;
    reg [7:0] tail_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = head_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // --------------------------------------------
    // Head always holds the oldest byte
    // --------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_reg <= 8'h00;
            tail_reg <= 8'h00;
            count_reg <= 2'h0;
        end
        else
        begin
            if (pop)
            begin
                head_reg <= (count_reg == 2'h2) ? tail_reg : in_data;
            end
            else if (push && count_reg == 2'h0)
            begin
                head_reg <= in_data;
            end
            if (push && (count_reg == 2'h2 || (count_reg == 2'h1 && !pop)))
            begin
                tail_reg <= in_data;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 2'h1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule

/* File: tb/boot_links_asserts.sv */
// Port-level checker for the boot link front end
`timescale 1ns/1ps
module boot_links_asserts (
    input wire clk,
    input wire rst_n,
    input wire boot_loader_active,
    input wire run_application,
    input wire [1:0] active_link,
    input wire baud_locked,
    input wire rx_overrun,
    input wire async_tx_pin,
    input wire rx_valid,
    input wire rx_ready,
    input wire [7:0] rx_data,
    input wire tx_valid,
    input wire tx_ready
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_boot_excl; !(boot_loader_active && run_application); endproperty
    a_boot_excl: assert property (p_boot_excl) else $error("both boot flags high");
    property p_boot_hold; boot_loader_active |=> boot_loader_active; endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("loader left");
    property p_link_hold; active_link != 2'h0 |=> $stable(active_link); endproperty
    a_link_hold: assert property (p_link_hold) else $error("link changed");
    property p_tx_quiet; !boot_loader_active |-> async_tx_pin; endproperty
    a_tx_quiet: assert property (p_tx_quiet) else $error("tx pin not idle");
    property p_tx_start; tx_valid && tx_ready && active_link == 2'h1 |=> !async_tx_pin; endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_ready_lock; tx_ready && active_link == 2'h1 |-> baud_locked; endproperty
    a_ready_lock: assert property (p_ready_lock) else $error("ready before lock");
    property p_lock_link; baud_locked |-> active_link == 2'h1; endproperty
    a_lock_link: assert property (p_lock_link) else $error("lock off async");
    property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx byte dropped");
    property p_ovr_sticky; rx_overrun |=> rx_overrun; endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun cleared");
endmodule

bind boot_links boot_links_asserts boot_links_asserts_inst (.clk, .rst_n, .boot_loader_active,
    .run_application, .active_link, .baud_locked, .rx_overrun, .async_tx_pin, .rx_valid,
    .rx_ready, .rx_data, .tx_valid, .tx_ready);

/* File: tb/host_model.sv */
// Update host model driving the async, synchronous and two-wire serial links
`timescale 1ns/1ps
module host_model (
    input wire clk,
    output reg async_rx_pin,
    output reg sync_frame_select_pin,
    output reg sync_serial_clock_pin,
    output reg sync_rx_pin,
    input wire sync_tx_pin,
    output reg two_wire_clock_pin,
    output reg two_wire_data_pin,
    input wire two_wire_line
);
    // ------------------------------------------------
    // Idle levels: lines high except sync_rx_pin low, serial clock parked high
    // ------------------------------------------------
    initial
    begin
        async_rx_pin = 1'b1;
        sync_frame_select_pin = 1'b1;
        sync_serial_clock_pin = 1'b1;
        sync_rx_pin = 1'b0;
        two_wire_clock_pin = 1'b1;
        two_wire_data_pin = 1'b1;
    end
    // Start, 8 data bits LSB first, one stop bit
    task uart(input [7:0] b, input integer per);
        integer i;
        reg [9:0] f;
        f = {1'b1, b, 1'b0};
        for (i = 0; i < 10; i = i + 1)
        begin
            async_rx_pin <= f[i];
            repeat (per) @(posedge clk);
        end
    endtask
    // Mode 3 exchange, MSB first, 80 ns clock
    task spi(input [7:0] b, output [7:0] r);
        integer i;
        #1.3;
        sync_frame_select_pin <= 1'b0;
        #40;
        for (i = 7; i >= 0; i = i - 1)
        begin
            sync_serial_clock_pin <= 1'b0;
            sync_rx_pin <= b[i];
            #40;
            sync_serial_clock_pin <= 1'b1;
            r[i] = sync_tx_pin;
            #40;
        end
        sync_frame_select_pin <= 1'b1;
        sync_rx_pin <= ~b[0]; // Stale data must not look valid
    endtask
    // Two-wire write at 400 kHz, both ack slots kept
    task iic(input [18:0] f, output [1:0] ack);
        integer i;
        @(posedge clk) two_wire_data_pin <= 1'b0;
        for (i = 18; i >= 0; i = i - 1)
        begin
            repeat (250) @(posedge clk);
            two_wire_clock_pin <= 1'b0;
            repeat (125) @(posedge clk);
            two_wire_data_pin <= f[i];
            repeat (125) @(posedge clk);
            two_wire_clock_pin <= 1'b1;
            if (i == 10 || i == 1)
                ack = {ack[0], two_wire_line};
        end
        repeat (250) @(posedge clk);
        two_wire_data_pin <= 1'b1;
    endtask
endmodule

/* File: tb/serial_boot_loader_links_tb.sv */
// Self-checking bench for the boot link front end
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks = total_checks + 1; if ((a) !== (e)) begin \
    n_mismatch = n_mismatch + 1; $display("unexpected %s expected %h seen %h", n, e, a); end end
module serial_boot_loader_links_tb;
    reg clk = 0, rst_n = 0, flash = 0, warm_entry = 0, rx_ready = 0, tx_valid = 1;
    reg [1:0] warm_link = 2'h0, a2;
    reg [15:0] warm_bit_period = 16'h0000;
    reg [7:0] tx_data = 8'h00, t, b, v;
    reg [7:0] d [0:2];
    integer n_mismatch = 0, total_checks = 0, cycles = 0, p, k;
    wire boot_loader_active, run_application, baud_locked, rx_overrun, async_tx_pin, sync_tx_pin;
    wire two_wire_data_oe, rx_valid, tx_ready, async_rx_pin, sync_frame_select_pin;
    wire sync_serial_clock_pin, sync_rx_pin, two_wire_clock_pin, two_wire_data_pin;
    wire two_wire_line = two_wire_data_pin & ~two_wire_data_oe;
    wire [1:0] active_link;
    wire [7:0] rx_data;
    // ------------------------------------------------
    // Design, host and clock
    // ------------------------------------------------
    boot_links boot_links_inst (.clk, .rst_n, .flash_words_all_ones(flash), .warm_entry,
        .warm_link, .warm_bit_period, .two_wire_master_enabled(1'b1), .boot_loader_active,
        .run_application, .active_link, .baud_locked, .rx_overrun, .async_rx_pin, .async_tx_pin,
        .sync_frame_select_pin, .sync_serial_clock_pin, .sync_rx_pin, .sync_tx_pin,
        .two_wire_clock_pin, .two_wire_data_in(two_wire_line), .two_wire_data_out(),
        .two_wire_data_oe, .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data);
    host_model host_model_inst (.clk, .async_rx_pin, .sync_frame_select_pin,
        .sync_serial_clock_pin, .sync_rx_pin, .sync_tx_pin, .two_wire_clock_pin,
        .two_wire_data_pin, .two_wire_line);
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Expected boot flags after reset
    function [1:0] boot_state(input f);
        boot_state = {f, ~f};
    endfunction
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task do_reset(input f);
        rst_n <= 1'b0;
        flash <= f;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("boot", boot_state(f), {boot_loader_active, run_application})
    endtask
    // Ready rises only once a byte waits
    task get_rx(output [7:0] x);
        @(negedge clk);
        while (!rx_valid) @(negedge clk);
        x = rx_data;
        @(posedge clk) rx_ready <= 1'b1;
        @(posedge clk) rx_ready <= 1'b0;
    endtask
    // Ready seen low phase: start bit begins at the next edge
    task get_tx(input integer per, output [7:0] x);
        integer i;
        @(negedge clk);
        while (!tx_ready) @(negedge clk);
        repeat (per / 2) @(negedge clk);
        for (i = 0; i < 8; i = i + 1)
        begin
            repeat (per) @(negedge clk);
            x[i] = async_tx_pin;
        end
        repeat (per) @(negedge clk);
        `CHK("stop bit", 1'b1, async_tx_pin)
    endtask
    // Hang guard above the longest expected run
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial
    begin
        t = $urandom(12);
        tx_data = t;
        do_reset(1'b0);
        @(posedge clk) warm_entry <= 1'b1;
        warm_link <= 2'h1;
        warm_bit_period <= 16'h0040;
        @(posedge clk) warm_entry <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("warm async", 3'h5, {baud_locked, active_link})
        get_tx(64, v);
        `CHK("tx byte", t, v)
        b = $urandom;
        host_model_inst.uart(b, 64);
        get_rx(v);
        `CHK("rx byte", b, v)
        $display("test 1 done");
        do_reset(1'b1);
        p = 40 + $urandom % 40;
        host_model_inst.uart(8'h55, p);
        repeat (3 * p) @(posedge clk);
        `CHK("auto baud", 3'h5, {baud_locked, active_link})
        get_tx(p, v);
        `CHK("tx at found rate", t, v)
        host_model_inst.spi(t, v);
        `CHK("link kept", 2'h1, active_link)
        $display("test 2 done");
        do_reset(1'b1);
        for (k = 0; k < 3; k = k + 1)
        begin
            d[k] = $urandom;
            @(posedge clk) tx_valid <= (k != 1);
            host_model_inst.spi(d[k], v);
            `CHK("sync tx", (k == 1) ? 8'h00 : t, v)
            #80;
        end
        `CHK("sync link", 2'h2, active_link)
        `CHK("overrun", 1'b1, rx_overrun)
        get_rx(v);
        `CHK("sync rx 0", d[0], v)
        get_rx(v);
        `CHK("sync rx 1", d[1], v)
        $display("test 3 done");
        do_reset(1'b1);
        b = $urandom;
        host_model_inst.iic({8'h86, 1'b1, b, 1'b1, 1'b0}, a2);
        `CHK("bad addr ack", 2'h3, a2)
        host_model_inst.iic({8'h84, 1'b1, b, 1'b1, 1'b0}, a2);
        `CHK("addr ack", 2'h0, a2)
        `CHK("wire link", 2'h3, active_link)
        get_rx(v);
        `CHK("wire rx", b, v)
        $display("test 4 done");
        end_of_test;
    end
endmodule
